/* File: hw/spfc_pkg.sv */
package spfc_pkg;
    // register byte addresses
    localparam logic [7:0] SPFC_CTRL_ADDR  = 8'h00;
    localparam logic [7:0] SPFC_LOCK_ADDR  = 8'h04;
    // control byte fields
    localparam int SPFC_IE_BIT   = 7;
    localparam int SPFC_BUSY_BIT = 6;
    localparam int SPFC_REEN_BIT = 4;
    localparam int SPFC_EN_BIT   = 0;
    localparam logic [7:0] SPFC_CTRL_RESET = 8'h00;
    // command patterns in the low five control bits; all but NONE are accepted
    localparam logic [4:0] SPFC_CMD_REEN = 5'h11;
    localparam logic [4:0] SPFC_CMD_LSET = 5'h09;
    localparam logic [4:0] SPFC_CMD_PWR  = 5'h05;
    localparam logic [4:0] SPFC_CMD_PER  = 5'h03;
    localparam logic [4:0] SPFC_CMD_FILL = 5'h01;
    localparam logic [4:0] SPFC_CMD_NONE = 5'h00;
    // lock byte fields, 1 = unprogrammed
    localparam int SPFC_BOOT_HI = 5;
    localparam int SPFC_BOOT_LO = 4;
    localparam int SPFC_APP_HI  = 3;
    localparam int SPFC_APP_LO  = 2;
    localparam int SPFC_GEN_HI  = 1;
    localparam int SPFC_GEN_LO  = 0;
    localparam logic [7:0] SPFC_LOCK_RESET = 8'hFF;
    // arming window in cycles; lowest armed count for a special read
    localparam logic [2:0] SPFC_ARM_CYCLES = 3'h4;
    localparam logic [2:0] SPFC_LPM_MIN    = 3'h2;
    // first page of the blocking (boot) section
    localparam logic [8:0] SPFC_BLOCKING_SECTION_PAGE  = 9'h1E0;
    localparam int SPFC_BUF_WORDS = 128;
    localparam logic [1:0] SPFC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] SPFC_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic        store;
        logic        load;
        logic [15:0] r1r0;
        logic [16:0] zptr;
        logic        exec_boot;
        logic        vec_boot;
        logic        gie;
    } spfc_cpu_req_t;

    typedef struct packed {
        logic       erase;
        logic       write;
        logic [8:0] page;
    } spfc_flash_cmd_t;

    typedef enum logic [1:0] {
        SPFC_IDLE  = 2'b00,
        SPFC_ARMED = 2'b01,
        SPFC_BUSY  = 2'b10
    } spfc_state_t;
endpackage

/* File: hw/spfc_top.sv */
// What this block does
// - ready interrupt while enabled and store idle
// - lower-section program start sets busy flag
// - busy clears on re-enable or buffer fill
// - re-enable armed four cycles, refused while busy
// - re-enable write aborts loaded buffer data
// - lock-set store programs application and boot locks from r0
// - lock-set clears on completion or timeout
// - special load within three cycles returns locks/fuses
// - page-write store writes buffer to pointer page
// - page-write self-clears; halt CPU for boot page
// - page-erase store erases pointer page, self-clears
// - enable alone arms buffer word fill
// - enable clears on store end, holds while busy
// - invalid command patterns are ignored
// - six lock bits, top bits read one
// - only chip erase or reset returns locks to one
// - general locks block external program and verify
// - application lock modes block writes/reads
// - application read lock suppresses interrupts
// - boot lock modes block writes/reads
// - boot read lock suppresses interrupts
// - pointer high part selects page, low word
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module spfc_top
    import spfc_pkg::*;
(
    input  wire logic            aclk,
    input  wire logic            aresetn,
    input  wire logic [7:0]      s_axi_awaddr,
    input  wire logic            s_axi_awvalid,
    output logic                 s_axi_awready,
    input  wire logic [31:0]     s_axi_wdata,
    input  wire logic [3:0]      s_axi_wstrb,
    input  wire logic            s_axi_wvalid,
    output logic                 s_axi_wready,
    output logic [1:0]           s_axi_bresp,
    output logic                 s_axi_bvalid,
    input  wire logic            s_axi_bready,
    input  wire logic [7:0]      s_axi_araddr,
    input  wire logic            s_axi_arvalid,
    output logic                 s_axi_arready,
    output logic [31:0]          s_axi_rdata,
    output logic [1:0]           s_axi_rresp,
    output logic                 s_axi_rvalid,
    input  wire logic            s_axi_rready,
    input  wire spfc_cpu_req_t   cpu,
    input  wire logic            flash_done,
    input  wire logic            chip_erase,
    input  wire logic [7:0]      fuse_low,
    input  wire logic [6:0]      buf_rd_addr,
    output logic [15:0]          buf_rd_data,
    output spfc_flash_cmd_t      flash_cmd,
    output logic                 special_valid,
    output logic [7:0]           special_data,
    output logic                 read_blocked,
    output logic                 ready_irq,
    output logic                 cpu_halt,
    output logic                 upper_section_busy,
    output logic                 irq_suppress,
    output logic                 ext_prog_block,
    output logic                 ext_verify_block
);
    spfc_state_t      state_reg;
    logic [4:0]       cmd_reg;
    logic [2:0]       wcnt_reg;
    logic             ie_reg;
    logic             busy_reg;
    logic             halt_reg;
    logic             opwr_reg;
    logic [7:0]       lock_reg;
    logic [15:0]      buf_mem [SPFC_BUF_WORDS];
    logic [SPFC_BUF_WORDS-1:0] bval_reg;
    logic [15:0]      buf_rd_reg;
    spfc_flash_cmd_t  fcmd_reg;
    logic             spec_v_reg;
    logic [7:0]       spec_d_reg;
    logic             rblk_reg;
    logic             aw_full_reg;
    logic [7:0]       aw_addr_reg;
    logic             w_full_reg;
    logic [7:0]       w_data_reg;
    logic             w_strb_reg;
    logic             bvalid_reg;
    logic [1:0]       bresp_reg;
    logic             rvalid_reg;
    logic [31:0]      rdata_reg;
    logic [1:0]       rresp_reg;
    wire wr_fire  = aw_full_reg & w_full_reg & ~bvalid_reg;
    wire wr_ctrl  = aw_addr_reg == SPFC_CTRL_ADDR;
    wire wr_map   = wr_ctrl | (aw_addr_reg == SPFC_LOCK_ADDR);
    wire ctrl_wr  = wr_fire & wr_ctrl & w_strb_reg;
    wire rd_fire  = s_axi_arvalid & ~rvalid_reg;
    wire rd_ctrl  = s_axi_araddr == SPFC_CTRL_ADDR;
    wire rd_lock  = s_axi_araddr == SPFC_LOCK_ADDR;
    wire [4:0] new_cmd = w_data_reg[4:0];
    wire cmd_valid = (new_cmd == SPFC_CMD_REEN) | (new_cmd == SPFC_CMD_LSET)
                   | (new_cmd == SPFC_CMD_PWR) | (new_cmd == SPFC_CMD_PER)
                   | (new_cmd == SPFC_CMD_FILL);
    wire accept   = ctrl_wr & cmd_valid & (state_reg != SPFC_BUSY);
    wire [7:0] ctrl_view = {ie_reg, busy_reg, 1'b0, cmd_reg};
    wire armed     = state_reg == SPFC_ARMED;
    wire store_hit = armed & cpu.store & ~accept;
    wire [8:0] tgt_page = cpu.zptr[16:8];
    wire tgt_blocking_section  = tgt_page >= SPFC_BLOCKING_SECTION_PAGE;
    wire app_wlock  = ~lock_reg[SPFC_APP_LO];
    wire app_rlock  = ~lock_reg[SPFC_APP_HI];
    wire boot_wlock = ~lock_reg[SPFC_BOOT_LO];
    wire boot_rlock = ~lock_reg[SPFC_BOOT_HI];
    wire wr_lock   = tgt_blocking_section ? boot_wlock : app_wlock;
    wire is_prog   = (cmd_reg == SPFC_CMD_PER) | (cmd_reg == SPFC_CMD_PWR);
    wire op_start  = store_hit & is_prog & ~wr_lock;
    wire fill_hit  = store_hit & (cmd_reg == SPFC_CMD_FILL);
    wire reen_hit  = store_hit & (cmd_reg == SPFC_CMD_REEN);
    wire lset_hit  = store_hit & (cmd_reg == SPFC_CMD_LSET);
    wire expire    = armed & ~cpu.store & ~accept
                   & (wcnt_reg == 3'h1);
    wire op_done   = (state_reg == SPFC_BUSY) & flash_done;
    wire spec_hit  = armed & (cmd_reg == SPFC_CMD_LSET) & cpu.load
                   & (wcnt_reg >= SPFC_LPM_MIN);
    wire ld_block  = cpu.load & ~spec_hit
                   & ((cpu.exec_boot & ~tgt_blocking_section & app_rlock)
                   | (~cpu.exec_boot & tgt_blocking_section & boot_rlock)
                   | (~tgt_blocking_section & busy_reg));
    assign s_axi_awready = ~aw_full_reg;
    assign s_axi_wready  = ~w_full_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign ready_irq = ie_reg & cpu.gie & ~cmd_reg[SPFC_EN_BIT];
    assign cpu_halt  = halt_reg;
    assign upper_section_busy = busy_reg;
    assign irq_suppress = (app_rlock & cpu.vec_boot & ~cpu.exec_boot)
                        | (boot_rlock & ~cpu.vec_boot & cpu.exec_boot);
    assign ext_prog_block   = ~lock_reg[SPFC_GEN_LO];
    assign ext_verify_block = ~lock_reg[SPFC_GEN_LO]
                            & ~lock_reg[SPFC_GEN_HI];
    assign flash_cmd     = fcmd_reg;
    assign special_valid = spec_v_reg;
    assign special_data  = spec_d_reg;
    assign read_blocked  = rblk_reg;
    assign buf_rd_data   = buf_rd_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_full_reg  <= 1'b0;
            w_data_reg  <= 8'h00;
            w_strb_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= SPFC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_full_reg) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_full_reg <= 1'b0;
            end
            if (s_axi_wvalid && !w_full_reg) begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata[7:0];
                w_strb_reg <= s_axi_wstrb[0];
            end else if (wr_fire) begin
                w_full_reg <= 1'b0;
            end
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_map ? SPFC_RESP_OKAY : SPFC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end
    // bus read channel; lock register is read-only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= SPFC_RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_ctrl ? {24'h00_0000, ctrl_view}
                        : rd_lock ? {24'h00_0000, lock_reg}
                        : 32'h0000_0000;
            rresp_reg  <= (rd_ctrl | rd_lock) ? SPFC_RESP_OKAY
                                              : SPFC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= SPFC_IDLE;
            cmd_reg   <= SPFC_CTRL_RESET[4:0];
            wcnt_reg  <= 3'h0;
            ie_reg    <= SPFC_CTRL_RESET[SPFC_IE_BIT];
            opwr_reg  <= 1'b0;
            fcmd_reg  <= '0;
        end else begin
            fcmd_reg.erase <= 1'b0;
            fcmd_reg.write <= 1'b0;
            if (ctrl_wr) begin
                ie_reg <= w_data_reg[SPFC_IE_BIT];
            end
            case (state_reg)
                SPFC_IDLE, SPFC_ARMED: begin
                    if (accept) begin
                        state_reg <= SPFC_ARMED;
                        cmd_reg   <= new_cmd;
                        wcnt_reg  <= SPFC_ARM_CYCLES;
                    end else if (op_start) begin
                        state_reg      <= SPFC_BUSY;
                        wcnt_reg       <= 3'h0;
                        opwr_reg       <= cmd_reg == SPFC_CMD_PWR;
                        fcmd_reg.erase <= cmd_reg == SPFC_CMD_PER;
                        fcmd_reg.write <= cmd_reg == SPFC_CMD_PWR;
                        fcmd_reg.page  <= tgt_page;
                    end else if (store_hit || expire) begin
                        state_reg <= SPFC_IDLE;
                        cmd_reg   <= SPFC_CMD_NONE;
                        wcnt_reg  <= 3'h0;
                    end else if (armed) begin
                        wcnt_reg <= wcnt_reg - 3'h1;
                    end
                end
                SPFC_BUSY: begin
                    if (flash_done) begin
                        state_reg <= SPFC_IDLE;
                        cmd_reg   <= SPFC_CMD_NONE;
                    end
                end
                default: begin
                    state_reg <= SPFC_IDLE;
                    cmd_reg   <= SPFC_CMD_NONE;
                end
            endcase
        end
    end
    // section busy, CPU halt and lock byte
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_reg <= SPFC_CTRL_RESET[SPFC_BUSY_BIT];
            halt_reg <= 1'b0;
            lock_reg <= SPFC_LOCK_RESET;
        end else begin
            if (op_start && !tgt_blocking_section) begin
                busy_reg <= 1'b1;
            end else if (reen_hit || fill_hit) begin
                busy_reg <= 1'b0;
            end
            if (op_start && tgt_blocking_section) begin
                halt_reg <= 1'b1;
            end else if (op_done) begin
                halt_reg <= 1'b0;
            end
            if (chip_erase) begin
                lock_reg <= SPFC_LOCK_RESET;
            end else if (lset_hit) begin
                // programming can only lower bits
                lock_reg[SPFC_BOOT_HI:SPFC_APP_LO] <=
                    lock_reg[SPFC_BOOT_HI:SPFC_APP_LO]
                    & cpu.r1r0[SPFC_BOOT_HI:SPFC_APP_LO];
            end
        end
    end
    // temporary page buffer; unloaded words read as erased
    always_ff @(posedge aclk) begin
        if (fill_hit) begin
            buf_mem[cpu.zptr[7:1]] <= cpu.r1r0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bval_reg   <= '0;
            buf_rd_reg <= 16'hFFFF;
        end else begin
            if (accept && new_cmd[SPFC_REEN_BIT]) begin
                bval_reg <= '0;
            end else if (op_done && opwr_reg) begin
                bval_reg <= '0;
            end else if (fill_hit) begin
                bval_reg[cpu.zptr[7:1]] <= 1'b1;
            end
            buf_rd_reg <= bval_reg[buf_rd_addr] ? buf_mem[buf_rd_addr]
                                                : 16'hFFFF;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            spec_v_reg <= 1'b0;
            spec_d_reg <= 8'h00;
            rblk_reg   <= 1'b0;
        end else begin
            spec_v_reg <= spec_hit;
            rblk_reg   <= ld_block;
            if (spec_hit) begin
                spec_d_reg <= cpu.zptr[0] ? lock_reg : fuse_low;
            end
        end
    end
    property p_irq;
        @(posedge aclk) disable iff (!aresetn)
        (state_reg == SPFC_IDLE && ie_reg && cpu.gie) |-> ready_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("ready irq missing");
    property p_busy_set;
        @(posedge aclk) disable iff (!aresetn)
        (op_start && !tgt_blocking_section) |=> busy_reg && state_reg == SPFC_BUSY;
    endproperty
    a_busy_set: assert property (p_busy_set) else $error("busy not set");
    property p_busy_hold;
        @(posedge aclk) disable iff (!aresetn)
        (state_reg == SPFC_BUSY) |-> cmd_reg[SPFC_EN_BIT]
            && ($past(state_reg) != SPFC_BUSY || $stable(busy_reg));
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("enable dropped during operation");
    property p_refuse;
        @(posedge aclk) disable iff (!aresetn)
        (state_reg == SPFC_BUSY && ctrl_wr && !flash_done)
            |=> state_reg == SPFC_BUSY && $stable(cmd_reg);
    endproperty
    a_refuse: assert property (p_refuse) else $error("taken while busy");
    property p_abort;
        @(posedge aclk) disable iff (!aresetn)
        (accept && new_cmd == SPFC_CMD_REEN) |=> bval_reg == '0;
    endproperty
    a_abort: assert property (p_abort) else $error("load not aborted");
    property p_expire;
        @(posedge aclk) disable iff (!aresetn)
        accept ##1 (!cpu.store && !ctrl_wr)[*4]
            |=> state_reg == SPFC_IDLE && cmd_reg == SPFC_CMD_NONE;
    endproperty
    a_expire: assert property (p_expire) else $error("no expiry");
    property p_invalid;
        @(posedge aclk) disable iff (!aresetn)
        (ctrl_wr && !cmd_valid && state_reg == SPFC_IDLE)
            |=> state_reg == SPFC_IDLE;
    endproperty
    a_invalid: assert property (p_invalid) else $error("bad armed");
    property p_lock_mono;
        @(posedge aclk) disable iff (!aresetn)
        !chip_erase |=> (lock_reg & ~$past(lock_reg)) == 8'h00;
    endproperty
    a_lock_mono: assert property (p_lock_mono) else $error("lock rose");
    property p_special;
        @(posedge aclk) disable iff (!aresetn)
        spec_hit |=> special_valid && special_data
            == ($past(cpu.zptr[0]) ? $past(lock_reg) : $past(fuse_low));
    endproperty
    a_special: assert property (p_special) else $error("bad special");
    property p_halt;
        @(posedge aclk) disable iff (!aresetn)
        (op_start && tgt_blocking_section) |=> cpu_halt throughout
            (state_reg == SPFC_BUSY);
    endproperty
    a_halt: assert property (p_halt) else $error("cpu not halted");
endmodule
`default_nettype wire

/* File: verification/spfc_cpu_model.sv */
`timescale 1ns/10ps
`default_nettype none
module spfc_cpu_model
    import spfc_pkg::*;
(
    input  wire logic            aclk,
    input  wire spfc_flash_cmd_t flash_cmd,
    input  wire logic [7:0]      done_delay,
    output var spfc_cpu_req_t    cpu,
    output var logic             flash_done
);
    int wait_cnt;

    initial begin
        cpu = '0;
        flash_done = 1'b0;
        wait_cnt = 0;
    end

    // flash array finishes a started erase or write after done_delay cycles
    always @(posedge aclk) begin
        flash_done <= 1'b0;
        if (flash_cmd.erase || flash_cmd.write) begin
            wait_cnt <= int'(done_delay);
        end else if (wait_cnt == 1) begin
            flash_done <= 1'b1;
            wait_cnt <= 0;
        end else if (wait_cnt > 1) begin
            wait_cnt <= wait_cnt - 1;
        end
    end

    // one store (st=1) or load (st=0) instruction; operands scrambled after
    task automatic op(input logic st, input logic [15:0] d,
                      input logic [16:0] z);
        @(posedge aclk);
        cpu.store <= st;
        cpu.load <= !st;
        cpu.r1r0 <= d;
        cpu.zptr <= z;
        @(posedge aclk);
        cpu.store <= 1'b0;
        cpu.load <= 1'b0;
        cpu.r1r0 <= ~d;
        cpu.zptr <= ~z;
    endtask

    task automatic lv(input logic g, input logic e, input logic v);
        @(posedge aclk);
        cpu.gie <= g;
        cpu.exec_boot <= e;
        cpu.vec_boot <= v;
    endtask
endmodule
`default_nettype wire

/* File: verification/spfc_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module spfc_top_tb;
    import spfc_pkg::*;
    localparam logic [7:0] ctl_a = SPFC_CTRL_ADDR;
    localparam logic [7:0] lck_a = SPFC_LOCK_ADDR;
    logic            aclk, aresetn, chip_erase, flash_done;
    logic [7:0]      s_axi_awaddr, s_axi_araddr, fuse_low, done_delay;
    logic            s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic            s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic            s_axi_rvalid, s_axi_rready;
    logic [31:0]     s_axi_wdata, s_axi_rdata;
    logic [3:0]      s_axi_wstrb;
    logic [1:0]      s_axi_bresp, s_axi_rresp;
    logic [6:0]      buf_rd_addr;
    logic [15:0]     buf_rd_data, d16;
    logic [7:0]      special_data;
    logic            special_valid, read_blocked, ready_irq, cpu_halt;
    logic            upper_section_busy, irq_suppress;
    logic            ext_prog_block, ext_verify_block;
    spfc_cpu_req_t   cpu;
    spfc_flash_cmd_t flash_cmd;
    int              bad_count, compares, cycles, seed;
    logic [31:0]     rq[$], fq[$], sq[$];
    logic [7:0]      bad_pat[4] = '{8'h07, 8'h1F, 8'h13, 8'h0B};

    spfc_top spfc_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu, .flash_done,
        .chip_erase, .fuse_low, .buf_rd_addr, .buf_rd_data, .flash_cmd,
        .special_valid, .special_data, .read_blocked, .ready_irq, .cpu_halt,
        .upper_section_busy, .irq_suppress, .ext_prog_block,
        .ext_verify_block);
    spfc_cpu_model spfc_cpu_model_i (.aclk, .flash_cmd, .done_delay, .cpu,
        .flash_done);

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic test_done;
        // a result that never appeared leaves its note behind
        if (rq.size() + fq.size() + sq.size() != 0) begin
            bad_count++;
        end
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask

    // an empty queue yields unknown, so an unexpected result fails
    function automatic logic [31:0] take(ref logic [31:0] q[$]);
        if (q.size() == 0) begin
            return 'x;
        end
        return q.pop_front();
    endfunction

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            test_done();
        end
        if (s_axi_rvalid && s_axi_rready) begin
            chk("rdata", take(rq), s_axi_rdata);
        end
        if (flash_cmd.erase || flash_cmd.write) begin
            chk("flash_cmd", take(fq), {21'h0, flash_cmd});
        end
        if (special_valid) begin
            chk("special_data", take(sq), {24'h0, special_data});
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [1:0] r = SPFC_RESP_OKAY);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                s_axi_bready <= 1'b0;
                chk("bresp", {30'h0, r}, {30'h0, s_axi_bresp});
                done = 1'b1;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] r = SPFC_RESP_OKAY);
        logic done;
        done = 1'b0;
        rq.push_back(e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                s_axi_rready <= 1'b0;
                chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
                done = 1'b1;
            end
        end
    endtask

    task automatic arm(input logic [4:0] c);
        wr(ctl_a, {3'h0, c});
    endtask

    initial begin
        seed = 97447;
        aresetn = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, chip_erase, buf_rd_addr} = '0;
        s_axi_wstrb = 4'hF;
        fuse_low = 8'($random(seed));
        d16 = 16'($random(seed));
        done_delay = 8'd30;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ctl_a, 32'h00);
        rd(lck_a, 32'hFF);
        rd(8'h08, 32'h00, SPFC_RESP_SLVERR);
        wr(lck_a, 8'h00);
        rd(lck_a, 32'hFF);
        arm(SPFC_CMD_FILL);
        spfc_cpu_model_i.op(1'b1, d16, {9'h000, 7'h15, 1'b1});
        buf_rd_addr <= 7'h15;
        repeat (2) @(posedge aclk);
        chk("buf_word", {16'h0, d16}, {16'h0, buf_rd_data});
        arm(SPFC_CMD_REEN);
        spfc_cpu_model_i.op(1'b1, 16'h0000, 17'h00000);
        repeat (3) @(posedge aclk);
        chk("buf_abort", 32'hFFFF, {16'h0, buf_rd_data});
        arm(SPFC_CMD_PER);
        fq.push_back({21'h0, 2'b10, 9'h005});
        spfc_cpu_model_i.op(1'b1, d16, {9'h005, 8'h00});
        rd(ctl_a, 32'h43);
        chk("upper_section_busy", 32'h1, {31'h0, upper_section_busy});
        arm(SPFC_CMD_FILL);
        rd(ctl_a, 32'h43);
        spfc_cpu_model_i.op(1'b0, 16'h0000, {9'h007, 8'h00});
        #1 chk("read_blocked", 32'h1, {31'h0, read_blocked});
        repeat (40) @(posedge aclk);
        rd(ctl_a, 32'h40);
        arm(SPFC_CMD_REEN);
        spfc_cpu_model_i.op(1'b1, 16'h0000, 17'h00000);
        rd(ctl_a, 32'h00);
        done_delay <= 8'd10;
        arm(SPFC_CMD_PER);
        fq.push_back({21'h0, 2'b10, SPFC_BLOCKING_SECTION_PAGE});
        spfc_cpu_model_i.op(1'b1, 16'h0000, {SPFC_BLOCKING_SECTION_PAGE, 8'h00});
        repeat (3) @(posedge aclk);
        chk("cpu_halt", 32'h1, {31'h0, cpu_halt});
        repeat (15) @(posedge aclk);
        chk("cpu_halt_end", 32'h0, {31'h0, cpu_halt});
        rd(ctl_a, 32'h00);
        for (int i = 0; i < 4; i++) begin
            wr(ctl_a, bad_pat[i]);
            spfc_cpu_model_i.op(1'b1, 16'h0000, {9'h005, 8'h00});
            rd(ctl_a, 32'h00);
        end
        arm(SPFC_CMD_PER);
        repeat (5) @(posedge aclk);
        spfc_cpu_model_i.op(1'b1, 16'h0000, {9'h005, 8'h00});
        rd(ctl_a, 32'h00);
        arm(SPFC_CMD_LSET);
        spfc_cpu_model_i.op(1'b1, 16'hAAF3, 17'h1FFFF);
        rd(lck_a, 32'hF3);
        rd(ctl_a, 32'h00);
        arm(SPFC_CMD_LSET);
        sq.push_back(32'hF3);
        spfc_cpu_model_i.op(1'b0, 16'h0000, 17'h00001);
        repeat (5) @(posedge aclk);
        rd(ctl_a, 32'h00);
        arm(SPFC_CMD_LSET);
        sq.push_back({24'h0, fuse_low});
        spfc_cpu_model_i.op(1'b0, 16'h0000, 17'h00000);
        spfc_cpu_model_i.lv(1'b0, 1'b0, 1'b1);
        repeat (2) @(posedge aclk);
        chk("irq_suppress", 32'h1, {31'h0, irq_suppress});
        spfc_cpu_model_i.lv(1'b0, 1'b1, 1'b0);
        repeat (2) @(posedge aclk);
        chk("irq_suppress", 32'h0, {31'h0, irq_suppress});
        arm(SPFC_CMD_PWR);
        spfc_cpu_model_i.op(1'b1, 16'h0000, {9'h005, 8'h00});
        rd(ctl_a, 32'h00);
        arm(SPFC_CMD_PWR);
        fq.push_back({21'h0, 2'b01, SPFC_BLOCKING_SECTION_PAGE});
        spfc_cpu_model_i.op(1'b1, 16'h1234, {SPFC_BLOCKING_SECTION_PAGE, 8'h00});
        repeat (15) @(posedge aclk);
        chip_erase <= 1'b1;
        @(posedge aclk);
        chip_erase <= 1'b0;
        rd(lck_a, 32'hFF);
        chk("ext_prog_block", 32'h0, {31'h0, ext_prog_block});
        chk("ext_verify_block", 32'h0, {31'h0, ext_verify_block});
        spfc_cpu_model_i.lv(1'b1, 1'b0, 1'b0);
        wr(ctl_a, 8'h80);
        chk("ready_irq", 32'h1, {31'h0, ready_irq});
        wr(ctl_a, 8'h81);
        chk("ready_irq_armed", 32'h0, {31'h0, ready_irq});
        repeat (6) @(posedge aclk);
        chk("ready_irq_expiry", 32'h1, {31'h0, ready_irq});
        rd(ctl_a, 32'h80);
        repeat (2) @(posedge aclk);
        test_done();
    end
endmodule
`default_nettype wire
